// ==== core/tsx_consts.vh ====
// Register offsets, field positions, encodings and reset values for tsx_core
`ifndef TSX_CONSTS_VH
`define TSX_CONSTS_VH

// APB register byte offsets
`define TSX_OFF_INSTR     8'h00
`define TSX_OFF_TPTR      8'h04
`define TSX_OFF_TLATCH    8'h08
`define TSX_OFF_ACCUM     8'h0C
`define TSX_OFF_STATUS    8'h10
`define TSX_OFF_BANK      8'h14
`define TSX_OFF_CTRL      8'h18
`define TSX_OFF_FADDR     8'h1C
`define TSX_OFF_FDATA     8'h20
`define TSX_OFF_FSR2      8'h24
`define TSX_OFF_HOLDWORD  8'h28
`define TSX_OFF_EXECSTAT  8'h2C

// Field positions
`define TSX_CTRL_EXT      0
`define TSX_CTRL_TWOWORD  1
`define TSX_STAT_ZERO     2
`define TSX_STAT_NEG      4
`define TSX_EXS_SKIP      2
`define TSX_EXS_ILLEGAL   3
`define TSX_EXS_BUSY      4

// Opcode patterns
`define TSX_TWRITE_HI     14'h0003
`define TSX_TSKIP_HI      7'h33
`define TSX_XORLIT_HI     8'h0A
`define TSX_MODE_NONE     2'h0
`define TSX_MODE_POSTINC  2'h1
`define TSX_MODE_POSTDEC  2'h2
`define TSX_MODE_PREINC   2'h3

// Addressing limits
`define TSX_INDEXED_MAX   8'h5F
`define TSX_ACC_SPLIT_STD 8'h80
`define TSX_ACC_SPLIT_EXT 8'h60
`define TSX_ACC_HI_BANK   4'hF

// Reset values
`define TSX_RST_TPTR      21'h000000
`define TSX_RST_BYTE      8'h00
`define TSX_RST_BANK      4'h0
`define TSX_RST_INSTR     16'h0000
`define TSX_RST_FADDR     12'h000
`define TSX_RST_CTRL      2'h1

// Phase counts
`define TSX_Q_LAST        2'h3
`define TSX_TABLE_WRITE_OP_CYCLES  2'h2
`define TSX_SKIP1_CYCLES  2'h2
`define TSX_SKIP2_CYCLES  2'h3
`define TSX_ONE_CYCLE     2'h1

`endif

// ==== core/tsx_core.v ====
// Table-write, test-skip-if-zero and XOR-literal execution unit, APB slave
//
// Behaviour
// - Decode table write: 0000 0000 0000 11nn
// - Mode selects none, post-inc, post-dec, pre-inc
// - Table latch byte goes to holding register
// - Table pointer is 21 bits, byte address
// - Pointer bit 0 picks low/high byte
// - Decode test-skip: 0110 011a ffff ffff
// - Zero operand discards next, two cycles
// - Skip over two-word instruction: three cycles
// - a=0 access bank, a=1 bank select
// - Extended, a=0, f<=95: indexed literal offset
// - Decode XOR literal: 0000 1010 kkkk kkkk
// - Accumulator XOR literal into accumulator
// - XOR literal updates only sign, zero
//
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "tsx_consts.vh"

module tsx_core (
    input  wire        clk_sys,
    input  wire        reset_n,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    output reg         execBusy
);

    // One-hot sequencer states
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_EXEC = 2'b10;

    reg  [1:0]  stateReg;
    reg  [1:0]  qPhaseReg;
    reg  [1:0]  cycleReg;
    reg  [1:0]  cyclesTotalReg;
    reg  [15:0] instrReg;
    reg  [20:0] tablePointerReg;
    reg  [7:0]  tableLatchReg;
    reg  [7:0]  accumReg;
    reg  [7:0]  statusReg;
    reg  [3:0]  bankSelectReg;
    reg  [1:0]  ctrlReg;
    reg  [11:0] fileAddrReg;
    reg  [11:0] fsr2Reg;
    reg  [7:0]  operandReg;
    reg         skipReg;
    reg         illegalReg;
    reg  [1:0]  lastCyclesReg;

    // Data memory and program-memory holding registers
    reg  [7:0]  fileMem [0:4095];
    reg  [7:0]  holdMem [0:63];

    // Decode of the captured instruction
    wire [1:0]  tblMode;
    wire        isTableWrite;
    wire        isTestSkip;
    wire        isXorLiteral;
    wire        accessSel;
    wire [7:0]  fileOffset;
    wire [7:0]  literalVal;

    assign isTableWrite = (instrReg[15:2] == `TSX_TWRITE_HI);
    assign tblMode      = instrReg[1:0];
    assign isTestSkip   = (instrReg[15:9] == `TSX_TSKIP_HI);
    assign accessSel    = instrReg[8];
    assign fileOffset   = instrReg[7:0];
    assign isXorLiteral = (instrReg[15:8] == `TSX_XORLIT_HI);
    assign literalVal   = instrReg[7:0];

    // Operand address formation for the test-skip instruction
    reg  [11:0] operandAddr;
    wire        extEnabled;
    wire [7:0]  accessSplit;

    assign extEnabled  = ctrlReg[`TSX_CTRL_EXT];
    assign accessSplit = extEnabled ? `TSX_ACC_SPLIT_EXT
                                    : `TSX_ACC_SPLIT_STD;

    always @* begin
        if (accessSel) begin
            operandAddr = {bankSelectReg, fileOffset};
        end else if (extEnabled && fileOffset <= `TSX_INDEXED_MAX) begin
            operandAddr = fsr2Reg + {4'h0, fileOffset};
        end else if (fileOffset < accessSplit) begin
            operandAddr = {4'h0, fileOffset};
        end else begin
            operandAddr = {`TSX_ACC_HI_BANK, fileOffset};
        end
    end

    // Table write addressing; pre-increment uses the advanced pointer
    wire [20:0] ptrPlusOne;
    wire [20:0] ptrMinusOne;
    wire [20:0] writeAddr;
    reg  [20:0] ptrAfter;

    // 21-bit pointer wraps in 2 Mbyte space
    assign ptrPlusOne  = tablePointerReg + 21'h000001;
    assign ptrMinusOne = tablePointerReg - 21'h000001;
    // pre-increment writes at pointer plus one
    assign writeAddr   = (tblMode == `TSX_MODE_PREINC) ? ptrPlusOne
                                                      : tablePointerReg;

    always @* begin
        case (tblMode)
            `TSX_MODE_NONE:    ptrAfter = tablePointerReg;
            `TSX_MODE_POSTINC: ptrAfter = ptrPlusOne;
            `TSX_MODE_POSTDEC: ptrAfter = ptrMinusOne;
            `TSX_MODE_PREINC:  ptrAfter = ptrPlusOne;
            default:           ptrAfter = tablePointerReg;
        endcase
    end

    // XOR result and its flags
    wire [7:0]  xorResult;
    wire [7:0]  xorStatus;

    assign xorResult = accumReg ^ literalVal;

    // only sign and zero bits replaced
    assign xorStatus = (statusReg
                        & ~((8'h01 << `TSX_STAT_ZERO)
                            | (8'h01 << `TSX_STAT_NEG)))
                       | ({7'h00, xorResult == 8'h00} << `TSX_STAT_ZERO)
                       | ({7'h00, xorResult[7]} << `TSX_STAT_NEG);

    // Bus handshake: one wait state, answer registered
    wire        busSetup;
    wire        busAccept;
    wire        writeAccept;
    wire        instrStart;
    wire        lastPhase;
    wire        mapped;

    assign busSetup    = psel & penable & ~pready;
    assign busAccept   = psel & penable & pready;
    assign writeAccept = busAccept & pwrite & ~pslverr;
    assign instrStart  = writeAccept && (paddr == `TSX_OFF_INSTR);
    assign lastPhase   = (qPhaseReg == `TSX_Q_LAST)
                         && (cycleReg == cyclesTotalReg - 2'h1);

    assign mapped = (paddr == `TSX_OFF_INSTR)   || (paddr == `TSX_OFF_TPTR)
                 || (paddr == `TSX_OFF_TLATCH)  || (paddr == `TSX_OFF_ACCUM)
                 || (paddr == `TSX_OFF_STATUS)  || (paddr == `TSX_OFF_BANK)
                 || (paddr == `TSX_OFF_CTRL)    || (paddr == `TSX_OFF_FADDR)
                 || (paddr == `TSX_OFF_FDATA)   || (paddr == `TSX_OFF_FSR2)
                 || (paddr == `TSX_OFF_HOLDWORD)
                 || (paddr == `TSX_OFF_EXECSTAT);

    // Read mux; holding word shows the pair the pointer lies in
    reg  [31:0] readData;
    wire [5:0]  holdLoIdx;
    wire [5:0]  holdHiIdx;

    // bit 0 clear is low byte, set is high
    assign holdLoIdx = {tablePointerReg[5:1], 1'b0};
    assign holdHiIdx = {tablePointerReg[5:1], 1'b1};

    always @* begin
        case (paddr)
            `TSX_OFF_INSTR:    readData = {16'h0000, instrReg};
            `TSX_OFF_TPTR:     readData = {11'h000, tablePointerReg};
            `TSX_OFF_TLATCH:   readData = {24'h000000, tableLatchReg};
            `TSX_OFF_ACCUM:    readData = {24'h000000, accumReg};
            `TSX_OFF_STATUS:   readData = {24'h000000, statusReg};
            `TSX_OFF_BANK:     readData = {28'h0000000, bankSelectReg};
            `TSX_OFF_CTRL:     readData = {30'h00000000, ctrlReg};
            `TSX_OFF_FADDR:    readData = {20'h00000, fileAddrReg};
            `TSX_OFF_FDATA:    readData = {24'h000000, fileMem[fileAddrReg]};
            `TSX_OFF_FSR2:     readData = {20'h00000, fsr2Reg};
            `TSX_OFF_HOLDWORD: readData = {16'h0000, holdMem[holdHiIdx],
                                           holdMem[holdLoIdx]};
            `TSX_OFF_EXECSTAT: readData = {27'h0000000, execBusy,
                                           illegalReg, skipReg,
                                           lastCyclesReg};
            default:           readData = 32'h00000000;
        endcase
    end

    // APB answer flops; writes refused while an instruction runs
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready <= busSetup;
            if (busSetup) begin
                prdata  <= pwrite ? 32'h00000000 : readData;
                pslverr <= ~mapped | (pwrite & execBusy);
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    // Sequencer: four Q phases per instruction cycle
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            stateReg       <= ST_IDLE;
            qPhaseReg      <= 2'h0;
            cycleReg       <= 2'h0;
            cyclesTotalReg <= `TSX_ONE_CYCLE;
            execBusy       <= 1'b0;
        end else begin
            case (stateReg)
                ST_IDLE: begin
                    if (instrStart) begin
                        stateReg       <= ST_EXEC;
                        qPhaseReg      <= 2'h0;
                        cycleReg       <= 2'h0;
                        execBusy       <= 1'b1;
                        cyclesTotalReg <=
                            (pwdata[15:2] == `TSX_TWRITE_HI)
                            ? `TSX_TABLE_WRITE_OP_CYCLES : `TSX_ONE_CYCLE;
                    end
                end
                ST_EXEC: begin
                    qPhaseReg <= qPhaseReg + 2'h1;
                    if (qPhaseReg == `TSX_Q_LAST) begin
                        cycleReg <= cycleReg + 2'h1;
                    end
                    // Skip length known once operand processed in Q3
                    if (isTestSkip && cycleReg == 2'h0
                        && qPhaseReg == 2'h2 && operandReg == 8'h00) begin
                        cyclesTotalReg <= ctrlReg[`TSX_CTRL_TWOWORD]
                                          ? `TSX_SKIP2_CYCLES
                                          : `TSX_SKIP1_CYCLES;
                    end
                    if (lastPhase) begin
                        stateReg <= ST_IDLE;
                        execBusy <= 1'b0;
                    end
                end
                default: begin
                    stateReg <= ST_IDLE;
                    execBusy <= 1'b0;
                end
            endcase
        end
    end

    // Core registers: bus writes when idle, execution results when busy
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            instrReg        <= `TSX_RST_INSTR;
            tablePointerReg <= `TSX_RST_TPTR;
            tableLatchReg   <= `TSX_RST_BYTE;
            accumReg        <= `TSX_RST_BYTE;
            statusReg       <= `TSX_RST_BYTE;
            bankSelectReg   <= `TSX_RST_BANK;
            ctrlReg         <= `TSX_RST_CTRL;
            fileAddrReg     <= `TSX_RST_FADDR;
            fsr2Reg         <= `TSX_RST_FADDR;
            operandReg      <= `TSX_RST_BYTE;
            skipReg         <= 1'b0;
            illegalReg      <= 1'b0;
            lastCyclesReg   <= 2'h0;
        end else if (writeAccept) begin
            case (paddr)
                `TSX_OFF_INSTR:  instrReg        <= pwdata[15:0];
                `TSX_OFF_TPTR:   tablePointerReg <= pwdata[20:0];
                `TSX_OFF_TLATCH: tableLatchReg   <= pwdata[7:0];
                `TSX_OFF_ACCUM:  accumReg        <= pwdata[7:0];
                `TSX_OFF_STATUS: statusReg       <= pwdata[7:0];
                `TSX_OFF_BANK:   bankSelectReg   <= pwdata[3:0];
                `TSX_OFF_CTRL:   ctrlReg         <= pwdata[1:0];
                `TSX_OFF_FADDR:  fileAddrReg     <= pwdata[11:0];
                `TSX_OFF_FSR2:   fsr2Reg         <= pwdata[11:0];
                default:         ;
            endcase
            if (paddr == `TSX_OFF_INSTR) begin
                skipReg    <= 1'b0;
                illegalReg <= 1'b0;
            end
        end else if (stateReg == ST_EXEC) begin
            // Q2 of first cycle: fetch test-skip operand
            if (isTestSkip && cycleReg == 2'h0 && qPhaseReg == 2'h1) begin
                operandReg <= fileMem[operandAddr];
            end
            // Q3 of first cycle: record skip decision
            if (isTestSkip && cycleReg == 2'h0 && qPhaseReg == 2'h2) begin
                // skip only on a zero operand
                skipReg <= (operandReg == 8'h00);
            end
            if (cycleReg == 2'h0 && qPhaseReg == 2'h0) begin
                illegalReg <= ~(isTableWrite | isTestSkip | isXorLiteral);
            end
            // Q4 of first cycle: accumulator and flags
            if (isXorLiteral && cycleReg == 2'h0
                && qPhaseReg == `TSX_Q_LAST) begin
                accumReg  <= xorResult;
                statusReg <= xorStatus;
            end
            // Q4 of second cycle: pointer update, no flag change
            if (isTableWrite && cycleReg == 2'h1
                && qPhaseReg == `TSX_Q_LAST) begin
                tablePointerReg <= ptrAfter;
            end
            if (lastPhase) begin
                lastCyclesReg <= cyclesTotalReg;
            end
        end
    end

    // Memory writes: file data from the bus, holding bytes from execution
    always @(posedge clk_sys) begin
        if (writeAccept && paddr == `TSX_OFF_FDATA) begin
            fileMem[fileAddrReg] <= pwdata[7:0];
        end
        // holding write in Q4 of cycle two
        if (stateReg == ST_EXEC && isTableWrite && cycleReg == 2'h1
            && qPhaseReg == `TSX_Q_LAST) begin
            // latch byte into addressed holding register
            // pointer bit 0 selects the byte lane
            holdMem[writeAddr[5:0]] <= tableLatchReg;
        end
    end

endmodule

// ==== tb/tsx_core_chk.sv ====
// Port-level assertions for the execution unit and its APB slave
`timescale 1ns/1ps
`include "tsx_consts.vh"

module tsx_core_chk (
    input wire        clk_sys,
    input wire        reset_n,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [7:0]  paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        execBusy
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    // Accepted instruction write and its opcode class
    wire instrGo = psel && penable && pready && pwrite && !pslverr
                   && (paddr == `TSX_OFF_INSTR);
    wire isXor   = (pwdata[15:8] == 8'h0A);
    wire isTbl   = (pwdata[15:2] == 14'h0003);
    wire isSkip  = (pwdata[15:9] == 7'h33);

    // One instruction cycle is four clocks of busy
    property p_xor_one;
        instrGo && isXor |=> execBusy[*4] ##1 !execBusy;
    endproperty
    a_xor_one: assert property (p_xor_one)
        else $error("xor literal busy length wrong");

    property p_tbl_two;
        instrGo && isTbl |=> execBusy[*8] ##1 !execBusy;
    endproperty
    a_tbl_two: assert property (p_tbl_two)
        else $error("table write busy length wrong");

    // Skip takes one, two or three cycles, never another length
    property p_skip_len;
        instrGo && isSkip |=> execBusy[*4] ##1 ((!execBusy) or
            (execBusy[*4] ##1 ((!execBusy) or
            (execBusy[*4] ##1 !execBusy))));
    endproperty
    a_skip_len: assert property (p_skip_len)
        else $error("test skip busy length wrong");

    property p_other_one;
        instrGo && !isXor && !isTbl && !isSkip
            |=> execBusy[*4] ##1 !execBusy;
    endproperty
    a_other_one: assert property (p_other_one)
        else $error("undecoded opcode busy length wrong");

    property p_busy_cause;
        $rose(execBusy) |-> $past(instrGo);
    endproperty
    a_busy_cause: assert property (p_busy_cause)
        else $error("busy rose without instruction write");

    property p_ready_wait;
        psel && penable && !pready |=> pready;
    endproperty
    a_ready_wait: assert property (p_ready_wait)
        else $error("pready not one cycle after access");

    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("pready held longer than one cycle");

    property p_unmapped;
        psel && penable && pready && (paddr > `TSX_OFF_EXECSTAT)
            |-> pslverr && (prdata == 32'h0);
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped access not refused");

    property p_wr_zero;
        pready && pwrite |-> (prdata == 32'h0) && psel && penable;
    endproperty
    a_wr_zero: assert property (p_wr_zero)
        else $error("write answer carries data");

    // Main scenarios reached
    c_xor: cover property (instrGo && isXor);
    c_tbl: cover property (instrGo && isTbl);
    c_skip3: cover property (instrGo && isSkip ##1 execBusy[*8] ##1 execBusy);
    c_refuse: cover property (pready && pwrite && pslverr);
endmodule

bind tsx_core tsx_core_chk tsx_core_chk_i (
    .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .execBusy(execBusy));

// ==== tb/tsx_core_tb_top.sv ====
// Self-checking bench for the table-write, test-skip and XOR unit
`timescale 1ns/1ps
`include "tsx_consts.vh"

module tsx_core_tb_top;
    logic        clk_sys = 1'h0;
    logic        reset_n = 1'h0;
    logic        psel    = 1'h0;
    logic        penable = 1'h0;
    logic        pwrite  = 1'h0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    wire [31:0]  prdata;
    wire         pready;
    wire         pslverr;
    wire         execBusy;
    int          fails   = 0;
    int          checks  = 0;
    int          cycles  = 0;
    int          n;
    logic [31:0] rd;
    logic        er;
    // Scenario tables: expected values worked out by hand
    logic [7:0]  xLit[3]  = '{8'hAF, 8'h1A, 8'h80};
    logic [7:0]  xAcc[3]  = '{8'h1A, 8'h00, 8'h80};
    logic [7:0]  xSt[3]   = '{8'hEB, 8'hEF, 8'hFB};
    logic [20:0] tBeg[4]  = '{21'h11, 21'h1FFFFF, 21'h0, 21'h1389A};
    logic [20:0] tEnd[4]  = '{21'h11, 21'h0, 21'h1FFFFF, 21'h1389B};
    logic [20:0] tWa[4]   = '{21'h11, 21'h1FFFFF, 21'h0, 21'h1389B};
    logic [11:0] mAdr[5]  = '{12'h210, 12'h211, 12'h005, 12'h305, 12'hF90};
    logic [7:0]  mVal[5]  = '{8'h00, 8'h05, 8'h09, 8'h00, 8'h00};
    logic [1:0]  sCtl[6]  = '{2'h1, 2'h3, 2'h1, 2'h1, 2'h0, 2'h0};
    logic [3:0]  sBank[6] = '{4'h2, 4'h2, 4'h2, 4'h0, 4'h0, 4'h0};
    logic [15:0] sIns[6]  = '{16'h6710, 16'h6710, 16'h6711, 16'h6605,
                              16'h6605, 16'h6690};
    logic [7:0]  sCyc[6]  = '{8'h2, 8'h3, 8'h1, 8'h2, 8'h1, 8'h2};
    logic [15:0] bad[3]   = '{16'h0008, 16'h0B05, 16'h6805};

    tsx_core tsx_core_i (
        .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .execBusy(execBusy));

    // 40 MHz system clock
    always #12.5 clk_sys = ~clk_sys;

    // Cycle ceiling, several times the expected run length
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            fails = fails + 1;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic cmpData(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmpErr(input logic got, input logic exp);
        cmpData({31'h0, got}, {31'h0, exp});
    endtask

    // APB transfer held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'h1;
        // Only the cycle ceiling ends a stalled transfer
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0);
        cmpData(rd, exp);
    endtask

    // Start an instruction, count clocks of busy
    task automatic exec(input logic [15:0] ins, input int clk4);
        apb(1'h1, `TSX_OFF_INSTR, {16'h0, ins});
        n = 0;
        do begin
            @(posedge clk_sys);
            if (execBusy === 1'h1) n++;
        end while (execBusy === 1'h1 && n < 64);
        cmpData(n, clk4);
    endtask

    initial begin
        repeat (6) @(posedge clk_sys);
        reset_n <= 1'h1;
        rdChk(`TSX_OFF_CTRL, 32'h1);
        rdChk(`TSX_OFF_TPTR, 32'h0);
        rdChk(`TSX_OFF_ACCUM, 32'h0);
        rdChk(`TSX_OFF_STATUS, 32'h0);
        rdChk(`TSX_OFF_EXECSTAT, 32'h0);
        // XOR literal; other status bits start set to show they stay
        apb(1'h1, `TSX_OFF_ACCUM, 32'hB5);
        apb(1'h1, `TSX_OFF_STATUS, 32'hFF);
        for (int i = 0; i < 3; i++) begin
            exec({8'h0A, xLit[i]}, 4);
            rdChk(`TSX_OFF_ACCUM, {24'h0, xAcc[i]});
            rdChk(`TSX_OFF_STATUS, {24'h0, xSt[i]});
        end
        // Write while busy is refused and leaves the accumulator alone
        apb(1'h1, `TSX_OFF_INSTR, 32'h0A0F);
        apb(1'h1, `TSX_OFF_ACCUM, 32'h55);
        cmpErr(er, 1'h1);
        n = 0;
        while (execBusy !== 1'h0 && n < 64) begin
            @(posedge clk_sys);
            n++;
        end
        rdChk(`TSX_OFF_ACCUM, 32'h8F);
        apb(1'h0, 8'h30, 32'h0);
        cmpErr(er, 1'h1);
        // Near-miss encodings are not executed
        for (int i = 0; i < 3; i++) begin
            exec(bad[i], 4);
            rdChk(`TSX_OFF_EXECSTAT, 32'h9);
        end
        // Table write, all four pointer modes with 21-bit wrap
        for (int i = 0; i < 4; i++) begin
            apb(1'h1, `TSX_OFF_TPTR, {11'h0, tBeg[i]});
            apb(1'h1, `TSX_OFF_TLATCH, 32'hA0 + i);
            exec(16'h000C + i[15:0], 8);
            rdChk(`TSX_OFF_TPTR, {11'h0, tEnd[i]});
            apb(1'h1, `TSX_OFF_TPTR, {11'h0, tWa[i]});
            apb(1'h0, `TSX_OFF_HOLDWORD, 32'h0);
            cmpData(tWa[i][0] ? rd[15:8] : rd[7:0], 32'hA0 + i);
        end
        rdChk(`TSX_OFF_STATUS, 32'hFB);
        rdChk(`TSX_OFF_EXECSTAT, 32'h2);
        // Data memory: zero only at the addresses that should skip
        for (int i = 0; i < 5; i++) begin
            apb(1'h1, `TSX_OFF_FADDR, {20'h0, mAdr[i]});
            apb(1'h1, `TSX_OFF_FDATA, {24'h0, mVal[i]});
        end
        apb(1'h1, `TSX_OFF_FSR2, 32'h300);
        for (int i = 0; i < 6; i++) begin
            apb(1'h1, `TSX_OFF_CTRL, {30'h0, sCtl[i]});
            apb(1'h1, `TSX_OFF_BANK, {28'h0, sBank[i]});
            exec(sIns[i], 4 * sCyc[i]);
            rdChk(`TSX_OFF_EXECSTAT,
                  {24'h0, sCyc[i] | ((sCyc[i] > 1) ? 8'h4 : 8'h0)});
        end
        rdChk(`TSX_OFF_STATUS, 32'hFB);
        end_of_test();
    end
endmodule
